// ===== stsg_pkg.sv
/*
 * Shared constants and types for the program-step timed output generator.
 * Assumes a single 250 MHz clock domain and a minute tick supplied from outside.
 */
package stsg_pkg;
	localparam int ENTRY_COUNT = 8;
	localparam int ENTRY_W = 3;
	localparam int HOUR_W = 7;
	localparam int MIN_W = 6;
	localparam int TIME_W = 13;
	localparam logic [MIN_W-1:0] MINUTES_PER_HOUR = 6'h3c;
	localparam logic [ENTRY_W-1:0] ENTRY_NONE = 3'h0;
	localparam logic [ENTRY_W-1:0] ENTRY_ALWAYS = 3'h1;
	localparam logic [TIME_W-1:0] TIME_ZERO = 13'h0000;
	localparam int SYNC_DEPTH = 3;

	// One timed entry: ON time and OFF time, each hours and minutes.
	typedef struct packed {
		logic [HOUR_W-1:0] onHours;
		logic [MIN_W-1:0] onMinutes;
		logic [HOUR_W-1:0] offHours;
		logic [MIN_W-1:0] offMinutes;
	} stsg_entry_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WAIT_ON,
		PH_DRIVE,
		PH_STOP
	} stsg_phase_t;
endpackage

// ===== stsg_time_signal.sv
/*
 * Timed output generator for one signal output within each program step.
 * Assumes the sequencer pulses stepStart on the first cycle of a step and
 * holds stepActive for the step, and that minuteTick is a one-cycle pulse
 * on this clock. Entry table inputs are static while a step runs.
 */
`timescale 1ns/10ps
module stsg_time_signal
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic stepStart,
	input wire logic stepActive,
	input wire logic minuteTick,
	input wire logic [stsg_pkg::ENTRY_W-1:0] timedOutputEntryNumber,
	input wire stsg_pkg::stsg_entry_t [stsg_pkg::ENTRY_COUNT-1:0] timedOutputEntry,
	output logic timeSignal,
	output logic [stsg_pkg::ENTRY_W-1:0] activeEntry
);
	function automatic logic [stsg_pkg::TIME_W-1:0] toMinutes(
		input logic [stsg_pkg::HOUR_W-1:0] hours,
		input logic [stsg_pkg::MIN_W-1:0] minutes);
		logic [stsg_pkg::TIME_W-1:0] total;
		total = stsg_pkg::TIME_W'(hours) * stsg_pkg::TIME_W'(stsg_pkg::MINUTES_PER_HOUR);
		total = total + stsg_pkg::TIME_W'(minutes);
		return total;
	endfunction

	// Entries 0 and 1 are plain levels; only the other entries run the timed cycle.
	function automatic logic isTimed(
		input logic [stsg_pkg::ENTRY_W-1:0] entry);
		logic timed;
		timed = (entry != stsg_pkg::ENTRY_NONE) && (entry != stsg_pkg::ENTRY_ALWAYS);
		return timed;
	endfunction

	function automatic logic intervalDone(
		input logic [stsg_pkg::TIME_W-1:0] count,
		input logic [stsg_pkg::TIME_W-1:0] limit);
		logic done;
		done = (count >= limit);
		return done;
	endfunction

	// The counter moves only on a minute tick, so the fast clock never sets the pace.
	function automatic logic [stsg_pkg::TIME_W-1:0] nextCount(
		input logic [stsg_pkg::TIME_W-1:0] count,
		input logic tick);
		logic [stsg_pkg::TIME_W-1:0] stepped;
		stepped = count;
		if (tick)
			stepped = count + 1'b1;
		return stepped;
	endfunction

	stsg_pkg::stsg_phase_t phase_r;
	stsg_pkg::stsg_phase_t phase_nxt;
	logic [stsg_pkg::TIME_W-1:0] count_r;
	logic [stsg_pkg::TIME_W-1:0] count_nxt;
	logic [stsg_pkg::ENTRY_W-1:0] entry_r;
	logic [stsg_pkg::ENTRY_W-1:0] entry_nxt;
	logic out_r;
	logic out_nxt;
	logic [stsg_pkg::TIME_W-1:0] onLimit;
	logic [stsg_pkg::TIME_W-1:0] offLimit;

	// Entry group: the selection is held for the whole step and changes only at a step start.
	always_comb
	begin
		entry_nxt = entry_r;
		if (stepStart)
		begin
			entry_nxt = timedOutputEntryNumber;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			entry_r <= stsg_pkg::ENTRY_NONE;
		end
		else
		begin
			entry_r <= entry_nxt;
		end
	end

	// Step group: phase and minute counter of the timed cycle.
	// A step start wins over everything else, so back-to-back steps each restart cleanly.
	always_comb
	begin
		onLimit = toMinutes(timedOutputEntry[entry_r].onHours, timedOutputEntry[entry_r].onMinutes);
		offLimit = toMinutes(timedOutputEntry[entry_r].offHours, timedOutputEntry[entry_r].offMinutes);
		phase_nxt = phase_r;
		count_nxt = count_r;
		if (stepStart)
		begin
			count_nxt = stsg_pkg::TIME_ZERO;
			if (isTimed(timedOutputEntryNumber))
			begin
				phase_nxt = stsg_pkg::PH_WAIT_ON;
			end
			else
			begin
				phase_nxt = stsg_pkg::PH_IDLE;
			end
		end
		else if (!stepActive)
		begin
			// Pending intervals are dropped so nothing leaks into the next step.
			phase_nxt = stsg_pkg::PH_IDLE;
			count_nxt = stsg_pkg::TIME_ZERO;
		end
		else
		begin
			unique case (phase_r)
				stsg_pkg::PH_IDLE:
				begin
					phase_nxt = stsg_pkg::PH_IDLE;
				end
				stsg_pkg::PH_WAIT_ON:
				begin
					if (intervalDone(count_r, onLimit))
					begin
						phase_nxt = stsg_pkg::PH_DRIVE;
						count_nxt = stsg_pkg::TIME_ZERO;
					end
					else
					begin
						count_nxt = nextCount(count_r, minuteTick);
					end
				end
				stsg_pkg::PH_DRIVE:
				begin
					// The drive phase lasts one cycle; the OFF time starts counting right after it.
					phase_nxt = stsg_pkg::PH_STOP;
					count_nxt = stsg_pkg::TIME_ZERO;
				end
				stsg_pkg::PH_STOP:
				begin
					if (intervalDone(count_r, offLimit))
					begin
						phase_nxt = stsg_pkg::PH_WAIT_ON;
						count_nxt = stsg_pkg::TIME_ZERO;
					end
					else
					begin
						count_nxt = nextCount(count_r, minuteTick);
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_r <= stsg_pkg::PH_IDLE;
			count_r <= stsg_pkg::TIME_ZERO;
		end
		else
		begin
			phase_r <= phase_nxt;
			count_r <= count_nxt;
		end
	end

	// Output group: the level is decided from the phase about to be entered.
	// This keeps the output register in step with the phase register, with no extra cycle of lag.
	// The level stays high for the drive phase and the first cycle of the stop phase.
	always_comb
	begin
		out_nxt = 1'b0;
		if (stepStart || stepActive)
		begin
			unique case (phase_nxt)
				stsg_pkg::PH_IDLE:
				begin
					out_nxt = (entry_nxt == stsg_pkg::ENTRY_ALWAYS);
				end
				stsg_pkg::PH_WAIT_ON:
				begin
					out_nxt = 1'b0;
				end
				stsg_pkg::PH_DRIVE:
				begin
					out_nxt = 1'b1;
				end
				stsg_pkg::PH_STOP:
				begin
					out_nxt = (phase_r == stsg_pkg::PH_DRIVE);
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_r <= 1'b0;
		end
		else
		begin
			out_r <= out_nxt;
		end
	end

	// Both outputs leave flip-flops directly.
	assign timeSignal = out_r;
	assign activeEntry = entry_r;
endmodule // stsg_time_signal

// ===== stsg_step_seq.sv
/* Program step sequencer model: step boundaries and minute ticks.
   Assumes the bench calls runStep from a process clocked by clk. */
`timescale 1ns/10ps
module stsg_step_seq #(parameter int TICK = 8)
(
	input wire logic clk,
	output logic stepStart = 1'b0,
	output logic stepActive = 1'b0,
	output logic minuteTick = 1'b0
);
	// The step ends half a minute after its last tick, so no rise sits on the boundary.
	task automatic runStep(input int len);
		for (int c = 0; c < len * TICK + TICK / 2; c++)
		begin
			@(posedge clk);
			stepStart <= (c == 0);
			stepActive <= 1'b1;
			minuteTick <= (c > 0) && (c % TICK == 0);
		end
		@(posedge clk);
		{stepStart, stepActive, minuteTick} <= 3'h0;
		repeat (2) @(posedge clk);
	endtask
endmodule // stsg_step_seq

// ===== stsg_time_signal_sva.sv
/* Port checker for stsg_time_signal.
   Assumes one clock domain and steps separated by at least one idle cycle. */
`timescale 1ns/10ps
module stsg_time_signal_chk
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic stepStart,
	input wire logic stepActive,
	input wire logic minuteTick,
	input wire logic [stsg_pkg::ENTRY_W-1:0] timedOutputEntryNumber,
	input wire stsg_pkg::stsg_entry_t [stsg_pkg::ENTRY_COUNT-1:0] timedOutputEntry,
	input wire logic timeSignal,
	input wire logic [stsg_pkg::ENTRY_W-1:0] activeEntry
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire stsg_pkg::stsg_entry_t sel = timedOutputEntry[timedOutputEntryNumber];
	wire logic onZero = {sel.onHours, sel.onMinutes} == 13'h0000;
	wire logic timed = timedOutputEntryNumber > 3'h1;
	entry_none_a: assert property (activeEntry == 3'h0 |-> !timeSignal) else $error("entry 0 on");
	entry_always_a: assert property (stepStart && timedOutputEntryNumber == 3'h1 |=> timeSignal) else $error("no on");
	always_hold_a: assert property (activeEntry == 3'h1 && stepActive && !stepStart |=> timeSignal) else $error("drop");
	end_clear_a: assert property (!stepActive && !stepStart |=> !timeSignal) else $error("end on");
	entry_latch_a: assert property (stepStart |=> activeEntry == $past(timedOutputEntryNumber)) else $error("latch");
	zero_on_a: assert property (stepStart && timed && onZero |=> !timeSignal ##1 timeSignal) else $error("on0");
	on_wait_a: assert property (stepStart && timed && !onZero |=> !timeSignal [*2]) else $error("early");
	rise_inside_a: assert property ($rose(timeSignal) |-> stepActive && $past(stepActive)) else $error("out");
	cover property (stepStart && timed && onZero);
	cover property ($rose(timeSignal) && activeEntry > 3'h1);
	cover property (stepStart && timedOutputEntryNumber == 3'h1);
endmodule // stsg_time_signal_chk
bind stsg_time_signal stsg_time_signal_chk u_stsg_time_signal_chk (.clk(clk), .rst_n(rst_n), .stepStart(stepStart),
	.stepActive(stepActive), .minuteTick(minuteTick), .timedOutputEntryNumber(timedOutputEntryNumber),
	.timedOutputEntry(timedOutputEntry), .timeSignal(timeSignal), .activeEntry(activeEntry));

// ===== stsg_time_signal_tb_top.sv
/* Random self-checking bench for stsg_time_signal: counts output rises per step.
   Assumes the sequencer model drives steps and minute ticks. */
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; $display("Error %s exp %0d got %0d", n, e, s); end end
module stsg_time_signal_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic stepStart, stepActive, minuteTick, timeSignal, prevSig = 1'b0, prevAct = 1'b0;
	logic [stsg_pkg::ENTRY_W-1:0] entryNum = 3'h0, activeEntry;
	stsg_pkg::stsg_entry_t [stsg_pkg::ENTRY_COUNT-1:0] entryTable = '0;
	int err_total = 0, n_checks = 0, expQ[$];
	logic [15:0] rises = 16'h0000;
	always #2 clk = ~clk;
	stsg_step_seq u_stsg_step_seq (.clk(clk), .stepStart(stepStart), .stepActive(stepActive), .minuteTick(minuteTick));
	stsg_time_signal u_stsg_time_signal (.clk(clk), .rst_n(rst_n), .stepStart(stepStart), .stepActive(stepActive),
		.minuteTick(minuteTick), .timedOutputEntryNumber(entryNum), .timedOutputEntry(entryTable),
		.timeSignal(timeSignal), .activeEntry(activeEntry));
	always @(posedge clk)
	begin
		prevSig <= timeSignal;
		prevAct <= stepActive;
		rises <= stepStart ? 0 : rises + (timeSignal && !prevSig);
		if (prevAct && !stepActive && expQ.size() > 0)
		begin
			`CHK("rises", expQ.pop_front(), rises)
			`CHK("entry", entryNum, activeEntry)
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		int e, on, off, len, n;
		void'($urandom(22951));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int t = 0; t < 30; t++)
		begin
			e = $urandom % 8;
			on = $urandom % 4 + 60 * ($urandom % 2);
			off = $urandom % 4 + 1;
			len = $urandom % 150 + 1;
			n = (e == 1);
			for (int k = on; e > 1 && k <= len; k += on + off)
				n++;
			@(posedge clk);
			entryNum <= 3'(e);
			entryTable[e] <= '{7'(on / 60), 6'(on % 60), 7'h00, 6'(off)};
			expQ.push_back(n);
			u_stsg_step_seq.runStep(len);
			$display("test %0d entry %0d done", t, e);
		end
		`CHK("pending", 0, expQ.size())
		finish_test();
	end
endmodule // stsg_time_signal_tb_top
